/* File: rtl/pic_cascade_map.svh */
`ifndef PIC_CASCADE_MAP_SVH
`define PIC_CASCADE_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFF_INIT_WORD_ONE   8'h00
`define OFF_INIT_WORD_FOUR  8'h04
`define OFF_SLAVE_INPUTS    8'h08
`define OFF_CASCADE_ID      8'h0c
`define OFF_VECTOR_BASE     8'h10
`define OFF_VECTOR_HIGH     8'h14
`define OFF_IN_SERVICE      8'h18
`define OFF_STATUS          8'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_LEVEL_TRIGGER   3
`define BIT_MODE_16         0
`define BIT_ROLE_MASTER     2
`define BIT_BUFFERED        3
`define BIT_SPECIAL_NESTED  4

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define RST_INIT_WORD_ONE   8'h00
`define RST_INIT_WORD_FOUR  8'h00
`define RST_SLAVE_INPUTS    8'h00
`define RST_CASCADE_ID      3'h0
`define RST_VECTOR_BASE     8'h00
`define RST_VECTOR_HIGH     8'h00
`define CALL_OPCODE         8'hcd
`define LOWEST_LINE         3'h7
`define NUM_LINES           8

`endif

/* File: rtl/pic_cascade_pkg.sv */
package pic_cascade_pkg;

    // ************************************************************
    // Acknowledge sequence states
    // ************************************************************
    typedef enum logic [5:0] {
        ACK_IDLE     = 6'b000001,
        ACK_PULSE1   = 6'b000010,
        ACK_BETWEEN1 = 6'b000100,
        ACK_PULSE2   = 6'b001000,
        ACK_BETWEEN2 = 6'b010000,
        ACK_PULSE3   = 6'b100000
    } ack_state_t;

    typedef logic [2:0] line_t;

endpackage

/* File: rtl/request_cell.sv */
`timescale 1ns/1ps
`default_nettype none

module request_cell (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic raw_request,
    input  wire logic level_mode,
    input  wire logic freeze,
    input  wire logic ack_clear,
    output var  logic pending_reg
);

    // ************************************************************
    // Input synchroniser
    // ************************************************************
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic rise;
    logic pending_next;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            sync1_reg <= raw_request;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // ************************************************************
    // Request latch
    // ************************************************************
    assign rise = sync2_reg & ~prev_reg;

    always_comb begin
        pending_next = pending_reg;
        if (!sync2_reg && !freeze)
            pending_next = 1'b0;
        else if (ack_clear)
            pending_next = 1'b0;
        else if (level_mode ? sync2_reg : rise)
            pending_next = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            pending_reg <= 1'b0;
        else
            pending_reg <= pending_next;
    end

endmodule

`default_nettype wire

/* File: rtl/pic_cascade.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pic_cascade_map.svh"

// How it works
// - Init word one bit 3 picks trigger
// - Edge mode: only rising edge requests
// - Edge mode: steady high input makes no new request
// - Level mode: high level requests, no edge
// - Request latch follows input while open
// - Vanished request answers with lowest line
// - Genuine lowest sets in-service, default does not
// - Init word four enables special nesting
// - Special nesting: busy slave input not locked
// - Normal nesting blocks in-service slave input
// - Buffered mode: pin enables data buffers
// - Word four bit 3 buffered, bit 2 role
// - One master, eight slaves, three-line cascade
// - Cascade code selects matching slave only
// - Slave drives vector bytes two, three (byte two only in 16-bit mode)
// - Master drives code first to last trailing (third, or second in 16-bit mode)
// - Cascade code nonzero only for slave inputs
module pic_cascade
    import pic_cascade_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata_reg,
    output var  logic        hreadyout_reg,
    output var  logic        hresp_reg,
    input  wire logic [7:0]  request_input,
    input  wire logic        interrupt_acknowledge_strobe_n,
    output var  logic        interrupt_out_reg,
    output var  logic [7:0]  vector_data_out_reg,
    output var  logic        vector_data_oe_reg,
    input  wire logic [2:0]  cascade_in,
    output var  logic [2:0]  cascade_out_reg,
    output var  logic        cascade_oe_reg,
    input  wire logic        buffer_enable_or_role_pin_in,
    output var  logic        buffer_enable_or_role_pin_n_out_reg,
    output var  logic        buffer_enable_or_role_pin_oe_reg
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0]  init_word_one_reg;
    logic [7:0]  init_word_four_reg;
    logic [7:0]  slave_inputs_reg;
    logic [2:0]  cascade_id_reg;
    logic [7:0]  vector_base_reg;
    logic [7:0]  vector_high_reg;
    logic [7:0]  in_service_bits_reg;
    logic [7:0]  in_service_bits_next;
    logic        role_strap_reg;
    logic        wr_pend_reg;
    logic        rd_pend_reg;
    logic [7:0]  acc_addr_reg;
    logic        ack_sync1_reg;
    logic        ack_sync2_reg;
    logic        ack_prev_reg;
    ack_state_t  state_reg;
    ack_state_t  state_next;
    line_t       chosen_reg;
    logic        genuine_reg;
    logic        respond_reg;
    logic [7:0]  pending;
    logic [7:0]  eligible;
    logic [8:0]  above;
    logic [7:0]  ack_clear;
    logic [7:0]  data_next;
    logic        data_oe_next;
    logic [2:0]  cascade_next;
    line_t       best;
    logic        any_eligible;
    logic        level_mode;
    logic        mode_16;
    logic        buffered;
    logic        special_nested;
    logic        is_master;
    logic        addr_phase;
    logic        wr_en;
    logic [31:0] rd_mux;
    logic        ack_fall;
    logic        ack_rise;
    logic        enter_pulse2;
    logic        slave_src;
    logic        responds_now;
    logic        last_trailing;
    logic [7:0]  isr_set;
    logic [7:0]  isr_clr;

    // ************************************************************
    // Mode decode
    // ************************************************************
    assign level_mode     = init_word_one_reg[`BIT_LEVEL_TRIGGER];
    assign mode_16        = init_word_four_reg[`BIT_MODE_16];
    assign buffered       = init_word_four_reg[`BIT_BUFFERED];
    assign special_nested = init_word_four_reg[`BIT_SPECIAL_NESTED];
    assign is_master      = buffered ? init_word_four_reg[`BIT_ROLE_MASTER]
                                     : role_strap_reg;

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    assign addr_phase = hsel & htrans[1] & hready;
    assign wr_en      = wr_pend_reg;

    assign rd_mux =
        (acc_addr_reg == `OFF_INIT_WORD_ONE)  ? {24'h0, init_word_one_reg} :
        (acc_addr_reg == `OFF_INIT_WORD_FOUR) ? {24'h0, init_word_four_reg} :
        (acc_addr_reg == `OFF_SLAVE_INPUTS)   ? {24'h0, slave_inputs_reg} :
        (acc_addr_reg == `OFF_CASCADE_ID)     ? {29'h0, cascade_id_reg} :
        (acc_addr_reg == `OFF_VECTOR_BASE)    ? {24'h0, vector_base_reg} :
        (acc_addr_reg == `OFF_VECTOR_HIGH)    ? {24'h0, vector_high_reg} :
        (acc_addr_reg == `OFF_IN_SERVICE)     ? {24'h0, in_service_bits_reg} :
        (acc_addr_reg == `OFF_STATUS)         ? {16'h0, pending, 2'h0,
                                                 is_master, genuine_reg,
                                                 state_reg[0], chosen_reg} :
        32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg   <= 1'b0;
            rd_pend_reg   <= 1'b0;
            acc_addr_reg  <= 8'h00;
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= 32'h0;
            hresp_reg     <= 1'b0;
        end else begin
            wr_pend_reg   <= addr_phase & hwrite;
            rd_pend_reg   <= addr_phase & ~hwrite;
            hreadyout_reg <= ~(addr_phase & ~hwrite);
            if (addr_phase)
                acc_addr_reg <= haddr;
            if (rd_pend_reg)
                hrdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_word_one_reg  <= `RST_INIT_WORD_ONE;
            init_word_four_reg <= `RST_INIT_WORD_FOUR;
            slave_inputs_reg   <= `RST_SLAVE_INPUTS;
            cascade_id_reg     <= `RST_CASCADE_ID;
            vector_base_reg    <= `RST_VECTOR_BASE;
            vector_high_reg    <= `RST_VECTOR_HIGH;
        end else if (wr_en) begin
            if (acc_addr_reg == `OFF_INIT_WORD_ONE)
                init_word_one_reg <= hwdata[7:0];
            if (acc_addr_reg == `OFF_INIT_WORD_FOUR)
                init_word_four_reg <= hwdata[7:0];
            if (acc_addr_reg == `OFF_SLAVE_INPUTS)
                slave_inputs_reg <= hwdata[7:0];
            if (acc_addr_reg == `OFF_CASCADE_ID)
                cascade_id_reg <= hwdata[2:0];
            if (acc_addr_reg == `OFF_VECTOR_BASE)
                vector_base_reg <= hwdata[7:0];
            if (acc_addr_reg == `OFF_VECTOR_HIGH)
                vector_high_reg <= hwdata[7:0];
        end
    end

    // ************************************************************
    // Role strap sampled every clock after reset release
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            role_strap_reg <= 1'b0;
        else
            role_strap_reg <= buffer_enable_or_role_pin_in;
    end

    // ************************************************************
    // Request cells
    // ************************************************************
    assign above[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < `NUM_LINES; i = i + 1) begin : g_line
            request_cell u_cell (
                .hclk        (hclk),
                .hresetn     (hresetn),
                .raw_request (request_input[i]),
                .level_mode  (level_mode),
                .freeze      (state_reg != ACK_IDLE),
                .ack_clear   (ack_clear[i]),
                .pending_reg (pending[i])
            );
            assign above[i+1] = above[i] | in_service_bits_reg[i];
            assign eligible[i] = pending[i] & ~above[i] &
                ~(in_service_bits_reg[i] &
                  ~(special_nested & is_master &
                    slave_inputs_reg[i]));
            assign ack_clear[i] = enter_pulse2 & responds_now & genuine_reg &
                                  (chosen_reg == line_t'(i));
            assign isr_set[i] = ack_clear[i];
            assign isr_clr[i] = wr_en & (acc_addr_reg == `OFF_IN_SERVICE) &
                                hwdata[i];
        end
    endgenerate

    always_comb begin
        best = `LOWEST_LINE;
        for (int k = `NUM_LINES - 1; k >= 0; k--) begin
            if (eligible[k])
                best = k[2:0];
        end
    end

    assign any_eligible = |eligible;

    // ************************************************************
    // In-service bits, set wins over clear
    // ************************************************************
    assign in_service_bits_next = (in_service_bits_reg & ~isr_clr) | isr_set;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            in_service_bits_reg <= 8'h00;
        else
            in_service_bits_reg <= in_service_bits_next;
    end

    // ************************************************************
    // Acknowledge strobe synchroniser
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_sync1_reg <= 1'b1;
            ack_sync2_reg <= 1'b1;
            ack_prev_reg  <= 1'b1;
        end else begin
            ack_sync1_reg <= interrupt_acknowledge_strobe_n;
            ack_sync2_reg <= ack_sync1_reg;
            ack_prev_reg  <= ack_sync2_reg;
        end
    end

    assign ack_fall = ~ack_sync2_reg & ack_prev_reg;
    assign ack_rise = ack_sync2_reg & ~ack_prev_reg;

    // ************************************************************
    // Acknowledge sequence
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ACK_IDLE:     if (ack_fall) state_next = ACK_PULSE1;
            ACK_PULSE1:   if (ack_rise) state_next = ACK_BETWEEN1;
            ACK_BETWEEN1: if (ack_fall) state_next = ACK_PULSE2;
            ACK_PULSE2:   if (ack_rise)
                              state_next = mode_16 ? ACK_IDLE : ACK_BETWEEN2;
            ACK_BETWEEN2: if (ack_fall) state_next = ACK_PULSE3;
            ACK_PULSE3:   if (ack_rise) state_next = ACK_IDLE;
        endcase
    end

    assign enter_pulse2  = (state_reg == ACK_BETWEEN1) & ack_fall;
    assign slave_src     = is_master & genuine_reg &
                           slave_inputs_reg[chosen_reg];
    assign responds_now  = is_master | (cascade_in == cascade_id_reg);
    assign last_trailing = ack_rise & ((state_reg == ACK_PULSE3) |
                           ((state_reg == ACK_PULSE2) & mode_16));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg   <= ACK_IDLE;
            chosen_reg  <= `LOWEST_LINE;
            genuine_reg <= 1'b0;
            respond_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if ((state_reg == ACK_IDLE) && ack_fall) begin
                chosen_reg  <= best;
                genuine_reg <= any_eligible;
            end
            if (enter_pulse2)
                respond_reg <= responds_now & ~slave_src;
            else if (last_trailing)
                respond_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Vector data and buffer enable
    // ************************************************************
    always_comb begin
        data_next    = 8'h00;
        data_oe_next = 1'b0;
        if ((state_next == ACK_PULSE1) && !mode_16 && is_master) begin
            data_next    = `CALL_OPCODE;
            data_oe_next = 1'b1;
        end else if (state_next == ACK_PULSE2 &&
                     (enter_pulse2 ? (responds_now & ~slave_src)
                                   : respond_reg)) begin
            data_next    = {vector_base_reg[7:3], chosen_reg};
            data_oe_next = 1'b1;
        end else if (state_next == ACK_PULSE3 && respond_reg) begin
            data_next    = vector_high_reg;
            data_oe_next = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vector_data_out_reg                 <= 8'h00;
            vector_data_oe_reg                  <= 1'b0;
            buffer_enable_or_role_pin_n_out_reg <= 1'b1;
            buffer_enable_or_role_pin_oe_reg    <= 1'b0;
        end else begin
            vector_data_out_reg                 <= data_next;
            vector_data_oe_reg                  <= data_oe_next;
            buffer_enable_or_role_pin_n_out_reg <= ~data_oe_next;
            buffer_enable_or_role_pin_oe_reg    <= buffered;
        end
    end

    // ************************************************************
    // Cascade bus and interrupt output
    // ************************************************************
    always_comb begin
        cascade_next = cascade_out_reg;
        if (last_trailing || state_next == ACK_IDLE)
            cascade_next = 3'h0;
        else if ((state_reg == ACK_PULSE1) && ack_rise && slave_src)
            cascade_next = chosen_reg;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cascade_out_reg   <= 3'h0;
            cascade_oe_reg    <= 1'b0;
            interrupt_out_reg <= 1'b0;
        end else begin
            cascade_out_reg   <= cascade_next;
            cascade_oe_reg    <= is_master;
            interrupt_out_reg <= any_eligible & (state_next == ACK_IDLE);
        end
    end

endmodule

`default_nettype wire

/* File: sim/pic_cascade_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Port relations of the controller
// ****************************************
module pic_cascade_monitor (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout_reg,
    input wire logic       hresp_reg,
    input wire logic [7:0] request_input,
    input wire logic       interrupt_acknowledge_strobe_n,
    input wire logic       interrupt_out_reg,
    input wire logic       vector_data_oe_reg,
    input wire logic [2:0] cascade_out_reg,
    input wire logic       buffer_enable_or_role_pin_n_out_reg,
    input wire logic       buffer_enable_or_role_pin_oe_reg
);
    wire logic ack_n = interrupt_acknowledge_strobe_n;
    wire logic sel_rd = hsel && htrans[1] && hready && !hwrite;
    wire logic casc_on = cascade_out_reg != 3'h0;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_resp_okay;
        hresp_reg == 1'b0;
    endproperty
    a_resp_okay: assert property (p_resp_okay)
        else $error("Response not OKAY");

    property p_read_wait;
        sel_rd |=> !hreadyout_reg ##1 hreadyout_reg;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("Read wait not one cycle");

    property p_data_on;
        $rose(vector_data_oe_reg) |-> $past(ack_n, 2) == 1'b0;
    endproperty
    a_data_on: assert property (p_data_on)
        else $error("Data driven without acknowledge");

    property p_data_off;
        $fell(vector_data_oe_reg) |-> $past(ack_n, 2) == 1'b1;
    endproperty
    a_data_off: assert property (p_data_off)
        else $error("Data released inside a pulse");

    property p_int_ack;
        $fell(ack_n) && interrupt_out_reg |-> ##[1:5] !interrupt_out_reg;
    endproperty
    a_int_ack: assert property (p_int_ack)
        else $error("Acknowledge not answered");

    property p_int_cause;
        $rose(interrupt_out_reg) |-> $past(request_input, 2) != 8'h00;
    endproperty
    a_int_cause: assert property (p_int_cause)
        else $error("Interrupt without request");

    property p_casc_quiet;
        casc_on |-> !interrupt_out_reg;
    endproperty
    a_casc_quiet: assert property (p_casc_quiet)
        else $error("Cascade code outside sequence");

    property p_casc_start;
        $rose(casc_on) |-> $past(ack_n, 2) == 1'b1;
    endproperty
    a_casc_start: assert property (p_casc_start)
        else $error("Cascade code before pulse end");

    property p_buf_en;
        buffer_enable_or_role_pin_oe_reg |->
            buffer_enable_or_role_pin_n_out_reg == !vector_data_oe_reg;
    endproperty
    a_buf_en: assert property (p_buf_en)
        else $error("Buffer enable mismatch");
endmodule

bind pic_cascade pic_cascade_monitor mon_u (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout_reg,
    .hresp_reg, .request_input, .interrupt_acknowledge_strobe_n,
    .interrupt_out_reg, .vector_data_oe_reg, .cascade_out_reg,
    .buffer_enable_or_role_pin_n_out_reg, .buffer_enable_or_role_pin_oe_reg
);

`default_nettype wire

/* File: sim/ack_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Host issuing acknowledge sequences
// ****************************************
module ack_host_model (
    input  wire logic       hclk,
    input  wire logic [7:0] data_in,
    input  wire logic       data_oe,
    input  wire logic [2:0] cascade_in,
    output var  logic       strobe_n
);
    logic [7:0] byte_seen [3];
    logic       oe_seen   [3];
    logic [2:0] code_seen;

    initial strobe_n = 1'b1;

    // Pulse of width clocks, gap between pulses of width plus one clocks; bytes taken at pulse end
    task automatic run(input int pulses, input int width);
        for (int i = 0; i < pulses; i++) begin
            @(posedge hclk);
            strobe_n <= 1'b0;
            repeat (width) @(posedge hclk);
            byte_seen[i] = data_in;
            oe_seen[i] = data_oe;
            if (i == 1) begin
                code_seen = cascade_in;
            end
            strobe_n <= 1'b1;
            repeat (width) @(posedge hclk);
        end
    endtask
endmodule

`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pic_cascade_map.svh"

module tb_top;
    localparam logic [7:0] vb = 8'h40;
    localparam logic [7:0] vh = 8'h12;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  request_input = 8'h00;
    logic [2:0]  cascade_in = 3'h0;
    logic        role_pin = 1'b1;
    int          n_tests = 0;
    int          err_total = 0;
    wire logic [31:0] hrdata_reg;
    wire logic [7:0]  data_out;
    wire logic [2:0]  cascade_out_reg;
    logic        hreadyout_reg, hresp_reg, ack_n;
    logic        interrupt_out_reg, data_oe, buf_oe, casc_oe;

    always #4 hclk = ~hclk;

    pic_cascade dut_u (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready(hreadyout_reg),
        .hrdata_reg, .hreadyout_reg, .hresp_reg, .request_input,
        .interrupt_acknowledge_strobe_n(ack_n), .interrupt_out_reg,
        .vector_data_out_reg(data_out), .vector_data_oe_reg(data_oe),
        .cascade_in, .cascade_out_reg, .cascade_oe_reg(casc_oe),
        .buffer_enable_or_role_pin_in(role_pin),
        .buffer_enable_or_role_pin_n_out_reg(),
        .buffer_enable_or_role_pin_oe_reg(buf_oe)
    );

    ack_host_model host_u (
        .hclk, .data_in(data_out), .data_oe, .cascade_in(cascade_out_reg),
        .strobe_n(ack_n)
    );

    // ****************************************
    // Bus, wait and compare tasks
    // ****************************************
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_hi(input string what, ref logic sig);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
            if (n > 300) begin
                chk(what, 32'h1, 32'(sig));
                final_report();
            end
        end while (sig !== 1'b1);
    endtask

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_hi("ready", hreadyout_reg);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_hi("ready", hreadyout_reg);
        rd = hrdata_reg;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        chk(what, exp, x);
    endtask

    task automatic chk_byte(input int i, input logic oe, input logic [7:0] b);
        chk("ack drive", 32'(oe), 32'(host_u.oe_seen[i]));
        if (oe) begin
            chk("ack byte", 32'(b), 32'(host_u.byte_seen[i]));
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        idle(6);
        hresetn <= 1'b1;
        idle(1);
        rd_chk("unmapped", 8'h20, 32'h0);
        wr(`OFF_VECTOR_BASE, {24'h0, vb});
        wr(`OFF_VECTOR_HIGH, {24'h0, vh});
        request_input <= 8'h08;
        wait_hi("interrupt", interrupt_out_reg);
        host_u.run(3, 6);
        chk_byte(0, 1'b1, `CALL_OPCODE);
        chk_byte(1, 1'b1, {vb[7:3], 3'h3});
        chk_byte(2, 1'b1, vh);
        chk("cascade", 32'h0, 32'(host_u.code_seen));
        chk("cascade drive", 32'h1, 32'(casc_oe));
        rd_chk("in service", `OFF_IN_SERVICE, 32'h08);
        wr(`OFF_IN_SERVICE, 32'hff);
        idle(20);
        chk("steady high", 32'h0, 32'(interrupt_out_reg));
        wr(`OFF_INIT_WORD_ONE, 32'h08);
        wait_hi("interrupt", interrupt_out_reg);
        host_u.run(3, 12);
        chk_byte(1, 1'b1, {vb[7:3], 3'h3});
        request_input <= 8'h00;
        idle(4);
        wr(`OFF_IN_SERVICE, 32'hff);
        idle(20);
        chk("level gone", 32'h0, 32'(interrupt_out_reg));
        wr(`OFF_INIT_WORD_ONE, 32'h00);
        request_input <= 8'h20;
        wait_hi("interrupt", interrupt_out_reg);
        request_input <= 8'h00;
        idle(6);
        host_u.run(3, 6);
        chk_byte(1, 1'b1, {vb[7:3], `LOWEST_LINE});
        rd_chk("in service", `OFF_IN_SERVICE, 32'h00);
        request_input <= 8'h80;
        wait_hi("interrupt", interrupt_out_reg);
        host_u.run(3, 6);
        chk_byte(1, 1'b1, {vb[7:3], `LOWEST_LINE});
        rd_chk("in service", `OFF_IN_SERVICE, 32'h80);
        wr(`OFF_IN_SERVICE, 32'hff);
        wr(`OFF_SLAVE_INPUTS, 32'h04);
        request_input <= 8'h04;
        wait_hi("interrupt", interrupt_out_reg);
        host_u.run(3, 6);
        chk("cascade", 32'h2, 32'(host_u.code_seen));
        chk("cascade idle", 32'h0, 32'(cascade_out_reg));
        request_input <= 8'h00;
        idle(4);
        request_input <= 8'h04;
        idle(20);
        chk("nested block", 32'h0, 32'(interrupt_out_reg));
        wr(`OFF_INIT_WORD_FOUR, 32'h1c);
        wait_hi("interrupt", interrupt_out_reg);
        host_u.run(3, 6);
        chk("cascade", 32'h2, 32'(host_u.code_seen));
        rd_chk("in service", `OFF_IN_SERVICE, 32'h04);
        wr(`OFF_IN_SERVICE, 32'hff);
        wr(`OFF_INIT_WORD_FOUR, 32'h09);
        wr(`OFF_CASCADE_ID, 32'h5);
        wr(`OFF_SLAVE_INPUTS, 32'h00);
        chk("buffer pin drive", 32'h1, 32'(buf_oe));
        chk("cascade drive", 32'h0, 32'(casc_oe));
        cascade_in <= 3'h3;
        request_input <= 8'h02;
        wait_hi("interrupt", interrupt_out_reg);
        host_u.run(2, 6);
        chk_byte(0, 1'b0, 8'h00);
        chk_byte(1, 1'b0, 8'h00);
        cascade_in <= 3'h5;
        request_input <= 8'h00;
        idle(4);
        request_input <= 8'h02;
        wait_hi("interrupt", interrupt_out_reg);
        host_u.run(2, 6);
        chk_byte(1, 1'b1, {vb[7:3], 3'h1});
        final_report();
    end
endmodule

`default_nettype wire
